// [pwr_regs.svh]
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH

// Register offsets
`define OFS_SLEEP_CTRL 8'h00
`define OFS_RAM_RETAIN 8'h04
`define OFS_CLK_CTRL   8'h08
`define OFS_WDOG_KICK  8'h0c
`define OFS_SW_RESET   8'h10
`define OFS_RST_CAUSE  8'h14
`define OFS_SLP_COUNT  8'h18
`define OFS_SLP_CMP    8'h1c
`define OFS_STATUS     8'h20
`define OFS_WAKE_EN    8'h24

// Field positions
`define CTRL_GO_BIT    2
`define CLK_XTAL_BIT   0
`define CLK_SLP1K_BIT  1
`define CLK_WDOG_BIT   2
`define WAKE_TMR_BIT   0
`define WAKE_PIN_BIT   1
`define CAUSE_DEEP_BIT 8

// Reset values
`define WAKE_EN_RST    2'h3
`define CAUSE_RST      9'h001

// Timing
`define SYS_CLK_MHZ     125
`define WAKE_SETTLE_NS  2000
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define RST_HOLD_NS     128
`define RST_HOLD_CYC    ((`RST_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000)
`define WDOG_TIMEOUT_US 1000
`define WDOG_CYC        (`WDOG_TIMEOUT_US * `SYS_CLK_MHZ)

`endif

// [pwr_pkg.sv]
package pwr_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_DS1  = 2'h1,
    MODE_DS2  = 2'h2,
    MODE_DS0  = 2'h3
  } sleep_mode_t;

  typedef enum logic [4:0] {
    ST_RUN  = 5'h01,
    ST_IDLE = 5'h02,
    ST_DS0  = 5'h04,
    ST_DEEP = 5'h08,
    ST_WAKE = 5'h10
  } pwr_state_t;

endpackage

// [sleep_timer.sv]
`timescale 1ns/1ns
module sleep_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] cmp,
  // Status
  output logic      [W-1:0] count,
  output logic              match
);

  logic [W-1:0] count_q;
  logic         match_q;
  wire          step = run & tick;
  wire  [W-1:0] count_d = count_q + {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_q <= '0;
      match_q <= 1'b0;
    end else begin
      if (step) begin
        count_q <= count_d;
      end
      match_q <= step & (count_d == cmp);
    end
  end

  assign count = count_q;
  assign match = match_q;

endmodule

// [sleep_power_reset_manager.sv]
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "pwr_regs.svh"
// Notes on behaviour
// - Idle halts CPU until interrupt, no resets
// - Deep sleep 1 powers core off, timer runs
// - Deep sleep 2 stops timer; timer cannot wake
// - Wake sources differ between mode 1 and 2
// - Mode 0 keeps core, resets non-debug peripherals
// - Always-on domain stays powered in every mode
// - RAM off in deep sleep unless retained
// - Retained banks fed from low-leakage supply
// - Flash domain fully off in deep sleep
// - Regulators off in deep sleep, on at wake
// - Central reset logic gathers all reset sources
// - Last reset cause recorded for software
// - Core power-up selects internal RC clock
// - Software may switch to crystal clock
// - 32-bit sleep timer wakes at programmed time
// - Optional watchdog resets on crash or lockup
// - Sleep timer ticks from crystal or 1 kHz
// - Lowest-power mode wakes only by pins
module sleep_power_reset_manager #(
  parameter int          BANKS   = 4,
  parameter int          PINS    = 8,
  parameter logic [31:0] WDOG_CYC = 32'(`WDOG_CYC)
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Register port
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic      [31:0]      rdata,
  // Reset sources
  input  wire logic             high_voltage_power_on_reset,
  input  wire logic             low_voltage_power_on_reset,
  input  wire logic             external_reset_pin_n,
  input  wire logic             option_byte_error,
  input  wire logic             debug_reset_req,
  input  wire logic             test_port_reset,
  input  wire logic             cpu_lockup,
  // Wake sources and timer ticks
  input  wire logic             irq_pending,
  input  wire logic [PINS-1:0]  pin_wake,
  input  wire logic             xtal_32k_tick,
  input  wire logic             rc_1k_tick,
  // Power controls
  output logic                  aon_pwr_en,
  output logic                  core_pwr_en,
  output logic                  flash_pwr_en,
  output logic                  reg_1v8_en,
  output logic                  reg_1v25_en,
  output logic      [BANKS-1:0] ram_pwr_en,
  output logic      [BANKS-1:0] ram_keep_en,
  output logic                  keep_reg_en,
  // Resets and clock control
  output logic                  cpu_rst,
  output logic                  periph_rst,
  output logic                  debug_rst,
  output logic                  cpu_halt,
  output logic                  clk_src_xtal
);

  pwr_pkg::pwr_state_t  state_q;
  pwr_pkg::pwr_state_t  state_d;
  pwr_pkg::sleep_mode_t mode_q;
  logic [BANKS-1:0]     retain_q;
  logic                 xtal_q;
  logic                 slp1k_q;
  logic                 wd_en_q;
  logic [1:0]           wake_en_q;
  logic [31:0]          cmp_q;
  logic [8:0]           cause_q;
  logic [4:0]           rst_cnt_q;
  logic                 dbg_rst_q;
  logic [8:0]           wk_cnt_q;
  logic [31:0]          wd_cnt_q;
  logic [31:0]          rdata_q;
  logic [31:0]          slp_count;
  logic                 tmr_match;

  // Address decode
  wire sel_ctrl   = addr == `OFS_SLEEP_CTRL;
  wire sel_retain = addr == `OFS_RAM_RETAIN;
  wire sel_clk    = addr == `OFS_CLK_CTRL;
  wire sel_kick   = addr == `OFS_WDOG_KICK;
  wire sel_swrst  = addr == `OFS_SW_RESET;
  wire sel_cause  = addr == `OFS_RST_CAUSE;
  wire sel_count  = addr == `OFS_SLP_COUNT;
  wire sel_cmp    = addr == `OFS_SLP_CMP;
  wire sel_status = addr == `OFS_STATUS;
  wire sel_wake   = addr == `OFS_WAKE_EN;

  wire go_w    = wr_stb & sel_ctrl & wdata[`CTRL_GO_BIT];
  wire kick_w  = wr_stb & sel_kick;
  wire sw_rst  = wr_stb & sel_swrst & wdata[0];
  wire in_run  = state_q == pwr_pkg::ST_RUN;
  wire in_idle = state_q == pwr_pkg::ST_IDLE;
  wire in_ds0  = state_q == pwr_pkg::ST_DS0;
  wire in_deep = state_q == pwr_pkg::ST_DEEP;
  wire in_wake = state_q == pwr_pkg::ST_WAKE;
  wire ds2     = mode_q == pwr_pkg::MODE_DS2;

  // Watchdog expiry or lockup while armed
  wire wd_fire = wd_en_q & (cpu_lockup | (wd_cnt_q == WDOG_CYC - 32'h1));

  // Reset sources, lowest bit has priority in the cause record
  wire pwr_on_any = high_voltage_power_on_reset | low_voltage_power_on_reset;
  wire [7:0] src_vec = {test_port_reset, debug_reset_req, option_byte_error,
                        sw_rst, wd_fire, ~external_reset_pin_n,
                        low_voltage_power_on_reset, high_voltage_power_on_reset};
  wire       src_any = |src_vec;
  wire [7:0] src_first = src_vec & (~src_vec + 8'h01);
  wire       core_hold = src_any | (rst_cnt_q != 5'h00);
  // Debug units are reset only by power-on and test-port resets and while in deep sleep
  wire       dbg_src = pwr_on_any | test_port_reset;

  // Sleep timer source and gating
  wire tmr_tick = slp1k_q ? rc_1k_tick : xtal_32k_tick;
  wire tmr_run  = ~(in_deep & ds2);

  // Mode 2 keeps only pin wake; mode 1 and mode 0 also take the timer
  wire pin_hit  = wake_en_q[`WAKE_PIN_BIT] & (|pin_wake);
  wire tmr_hit  = wake_en_q[`WAKE_TMR_BIT] & tmr_match & ~ds2;
  wire wake_hit = pin_hit | tmr_hit;

  sleep_timer #(
    .W (32)
  ) u_sleep_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (tmr_run),
    .tick    (tmr_tick),
    .cmp     (cmp_q),
    .count   (slp_count),
    .match   (tmr_match)
  );

  // Power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      pwr_pkg::ST_RUN: begin
        if (go_w) begin
          case (wdata[1:0])
            pwr_pkg::MODE_IDLE: state_d = pwr_pkg::ST_IDLE;
            pwr_pkg::MODE_DS0:  state_d = pwr_pkg::ST_DS0;
            default:            state_d = pwr_pkg::ST_DEEP;
          endcase
        end
      end
      pwr_pkg::ST_IDLE: begin
        if (irq_pending) begin
          state_d = pwr_pkg::ST_RUN;
        end
      end
      pwr_pkg::ST_DS0, pwr_pkg::ST_DEEP: begin
        if (wake_hit) begin
          state_d = pwr_pkg::ST_WAKE;
        end
      end
      pwr_pkg::ST_WAKE: begin
        if (wk_cnt_q == 9'h000) begin
          state_d = pwr_pkg::ST_RUN;
        end
      end
      default: state_d = pwr_pkg::ST_RUN;
    endcase
    // A reset always returns to run; sleep requests are refused meanwhile
    if (core_hold) begin
      state_d = pwr_pkg::ST_RUN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= pwr_pkg::ST_RUN;
      mode_q  <= pwr_pkg::MODE_IDLE;
    end else begin
      state_q <= state_d;
      if (go_w && in_run && !core_hold) begin
        mode_q <= pwr_pkg::sleep_mode_t'(wdata[1:0]);
      end
    end
  end

  // Wake settling: regulators and domains up, core held in reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wk_cnt_q <= 9'h000;
    end else if (state_d == pwr_pkg::ST_WAKE && !in_wake) begin
      wk_cnt_q <= 9'(`WAKE_SETTLE_CYC);
    end else if (wk_cnt_q != 9'h000) begin
      wk_cnt_q <= wk_cnt_q - 9'h001;
    end
  end

  // Reset stretch and cause record
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_cnt_q <= 5'(`RST_HOLD_CYC);
      dbg_rst_q <= 1'b1;
      cause_q   <= `CAUSE_RST;
    end else begin
      if (src_any) begin
        rst_cnt_q <= 5'(`RST_HOLD_CYC);
        cause_q   <= {1'b0, src_first};
      end else if (rst_cnt_q != 5'h00) begin
        rst_cnt_q <= rst_cnt_q - 5'h01;
      end else if (state_d == pwr_pkg::ST_WAKE && !in_wake) begin
        cause_q <= 9'h001 << `CAUSE_DEEP_BIT;
      end
      if (dbg_src) begin
        dbg_rst_q <= 1'b1;
      end else if (rst_cnt_q <= 5'h01) begin
        dbg_rst_q <= 1'b0;
      end
    end
  end

  // Software-visible control
  always_ff @(posedge sys_clk) begin
    if (sys_rst || pwr_on_any) begin
      retain_q  <= '0;
      cmp_q     <= 32'h0000_0000;
      wake_en_q <= `WAKE_EN_RST;
      slp1k_q   <= 1'b0;
    end else if (wr_stb) begin
      if (sel_retain) begin
        retain_q <= wdata[BANKS-1:0];
      end
      if (sel_cmp) begin
        cmp_q <= wdata;
      end
      if (sel_wake) begin
        wake_en_q <= wdata[1:0];
      end
      if (sel_clk) begin
        slp1k_q <= wdata[`CLK_SLP1K_BIT];
      end
    end
  end

  // Core-domain control falls back to defaults on any core reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xtal_q  <= 1'b0;
      wd_en_q <= 1'b0;
    end else if (core_hold || in_wake || in_deep || in_ds0) begin
      xtal_q  <= 1'b0;
      wd_en_q <= 1'b0;
    end else if (wr_stb && sel_clk) begin
      xtal_q  <= wdata[`CLK_XTAL_BIT];
      wd_en_q <= wdata[`CLK_WDOG_BIT];
    end
  end

  // Watchdog only counts while code runs; a write to the kick register restarts it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || core_hold || kick_w || !wd_en_q || !in_run) begin
      wd_cnt_q <= 32'h0000_0000;
    end else begin
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end
  end

  // Read path, unmapped offsets read zero
  wire [31:0] status_w = {22'h0, core_hold, dbg_rst_q,
                          2'(mode_q), 5'(state_q), clk_src_xtal};
  wire [31:0] rd_val =
    sel_ctrl   ? {30'h0, 2'(mode_q)} :
    sel_retain ? {{(32-BANKS){1'b0}}, retain_q} :
    sel_clk    ? {29'h0, wd_en_q, slp1k_q, xtal_q} :
    sel_cause  ? {23'h0, cause_q} :
    sel_count  ? slp_count :
    sel_cmp    ? cmp_q :
    sel_status ? status_w :
    sel_wake   ? {30'h0, wake_en_q} : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_stb ? rd_val : 32'h0000_0000;
    end
  end

  // Power and reset outputs
  assign aon_pwr_en   = 1'b1;
  assign core_pwr_en  = ~in_deep;
  assign flash_pwr_en = ~in_deep;
  assign reg_1v8_en   = ~in_deep;
  assign reg_1v25_en  = ~in_deep;
  assign ram_pwr_en   = in_deep ? '0 : '1;
  assign ram_keep_en  = in_deep ? retain_q : '0;
  assign keep_reg_en  = in_deep & (|retain_q);
  assign cpu_rst      = core_hold | in_ds0 | in_deep | in_wake;
  assign periph_rst   = core_hold | in_ds0 | in_deep | in_wake;
  assign debug_rst    = dbg_rst_q | in_deep;
  assign cpu_halt     = in_idle;
  assign clk_src_xtal = xtal_q;
  assign rdata        = rdata_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_idle_powered: assert property (in_idle |-> core_pwr_en && flash_pwr_en && cpu_halt
                                   && !cpu_rst && !periph_rst)
    else $error("idle sleep lost power or asserted reset");
  a_idle_exit: assert property (in_idle && irq_pending && !core_hold |=> in_run)
    else $error("idle did not end on interrupt");
  a_ds1_core_off: assert property (in_deep && !ds2 && tmr_tick |-> !core_pwr_en
                                   ##1 slp_count == $past(slp_count) + 32'h1)
    else $error("deep sleep 1 power or timer wrong");
  a_ds2_timer_stop: assert property (in_deep && ds2 ##1 in_deep |-> $stable(slp_count))
    else $error("sleep timer moved in deep sleep 2");
  a_ds2_no_tmr_wake: assert property (in_deep && ds2 && !pin_hit && !core_hold
                                      |=> in_deep)
    else $error("deep sleep 2 woke without a pin");
  a_ds0_debug: assert property (in_ds0 |-> core_pwr_en && periph_rst && cpu_rst
                                && (debug_rst == dbg_rst_q))
    else $error("emulated sleep reset pattern wrong");
  a_aon_on: assert property (aon_pwr_en)
    else $error("always-on domain dropped");
  a_ram_keep: assert property (in_deep |-> ram_keep_en == retain_q && ram_pwr_en == '0
                               && !flash_pwr_en)
    else $error("RAM or flash power wrong in deep sleep");
  a_regs_back: assert property ($fell(in_deep) |-> reg_1v8_en && reg_1v25_en)
    else $error("regulators not restored on wake");
  a_cause_rec: assert property (src_any |=> cause_q == {1'b0, $past(src_first)})
    else $error("reset cause not recorded");
  a_reset_hold: assert property (src_any |=> cpu_rst [*8])
    else $error("reset source not stretched");
  a_wake_done: assert property ($rose(in_wake) |-> !clk_src_xtal [*2]
                                ##[1:260] in_run)
    else $error("wake sequence did not finish on RC clock");
  a_wdog_lock: assert property (wd_en_q && cpu_lockup |=> cpu_rst && !wd_en_q)
    else $error("lockup did not reset");

  c_idle_trip: cover property (in_idle ##1 in_run);
  c_ds1_timer: cover property (in_deep && !ds2 && tmr_hit ##1 in_wake);
  c_ds2_pin: cover property (in_deep && ds2 && pin_hit ##1 in_wake);
  c_ds0_wake: cover property (in_ds0 ##1 in_wake);
  c_wdog_fire: cover property (wd_fire && !cpu_lockup);

endmodule

// [wake_source_model.sv]
`timescale 1ns/1ns
module wake_source_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Requests from the bench
  input  wire logic [7:0] pin_req,
  input  wire logic       irq_req,
  // Wake sources and timer ticks
  output logic      [7:0] pin_wake,
  output logic            irq_pending,
  output logic            xtal_32k_tick,
  output logic            rc_1k_tick
);
  logic [3:0] div_q;

  // Tick rates are scaled far above the real ones so timer wakes fit a short run
  always_ff @(posedge sys_clk) begin
    if (sys_rst) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end
  assign xtal_32k_tick = (div_q[1:0] == 2'h3);
  assign rc_1k_tick    = (div_q == 4'hf);
  // Pins and interrupt are levels held for as long as the bench asks
  assign pin_wake      = pin_req;
  assign irq_pending   = irq_req;
endmodule

// [sleep_power_reset_manager_bench.sv]
`timescale 1ns/1ns
`include "pwr_regs.svh"
module sleep_power_reset_manager_bench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  src = 8'h00;
  logic        cpu_lockup = 1'b0;
  logic [7:0]  pin_req = 8'h00;
  logic        irq_req = 1'b0;
  logic [7:0]  pin_wake;
  logic        irq_pending, xtal_tick, rc_tick;
  logic        aon, core, flash, r18, r125, keep_reg;
  logic        cpu_rst, periph_rst, debug_rst, cpu_halt, xtal;
  logic [3:0]  ram_pwr, ram_keep;
  logic [31:0] seed = 32'h28822e92;
  logic [31:0] rd_v;
  int          errors = 0;
  int          checks_done = 0;
  int          k;

  always #4 sys_clk = ~sys_clk;

  wake_source_model wake_source_model_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_req(pin_req), .irq_req(irq_req),
    .pin_wake(pin_wake), .irq_pending(irq_pending), .xtal_32k_tick(xtal_tick),
    .rc_1k_tick(rc_tick));

  sleep_power_reset_manager #(.WDOG_CYC(32'h40)) sleep_power_reset_manager_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .high_voltage_power_on_reset(src[0]), .low_voltage_power_on_reset(src[1]),
    .external_reset_pin_n(~src[2]), .option_byte_error(src[5]),
    .debug_reset_req(src[6]), .test_port_reset(src[7]), .cpu_lockup(cpu_lockup),
    .irq_pending(irq_pending), .pin_wake(pin_wake), .xtal_32k_tick(xtal_tick),
    .rc_1k_tick(rc_tick), .aon_pwr_en(aon), .core_pwr_en(core), .flash_pwr_en(flash),
    .reg_1v8_en(r18), .reg_1v25_en(r125), .ram_pwr_en(ram_pwr), .ram_keep_en(ram_keep),
    .keep_reg_en(keep_reg), .cpu_rst(cpu_rst), .periph_rst(periph_rst),
    .debug_rst(debug_rst), .cpu_halt(cpu_halt), .clk_src_xtal(xtal));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_v);
    check(rd_v, exp);
  endtask

  // Running means out of reset, core powered and not halted
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while ((cpu_rst !== 1'b0 || core !== 1'b1 || cpu_halt !== 1'b0) && n < lim) begin
      settle();
      n++;
    end
    if (n >= lim) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wake_by_pin();
    @(posedge sys_clk);
    seed = lfsr(seed);
    pin_req <= 8'h01 << seed[2:0];
    repeat (2) @(posedge sys_clk);
    pin_req <= 8'h00;
    wait_run(400);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_run(40);
    rd_check(`OFS_RST_CAUSE, 32'h001);
    check({aon, core, flash, r18, r125, ram_pwr}, 9'h1ff);
    rd_check(8'h3c, 32'h0);
    seed = lfsr(seed);
    wr(`OFS_RAM_RETAIN, seed);
    rd_check(`OFS_RAM_RETAIN, {28'h0, seed[3:0]});
    // Idle sleep: halted, everything powered, no reset, interrupt ends it
    wr(`OFS_SLEEP_CTRL, 32'h4);
    settle();
    check({cpu_halt, cpu_rst, periph_rst, debug_rst, core, flash}, 6'h23);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    wait_run(10);
    @(posedge sys_clk);
    irq_req <= 1'b0;
    // Deep sleep 1 with retention, crystal selected beforehand
    wr(`OFS_CLK_CTRL, 32'h1);
    settle();
    check(xtal, 1'b1);
    seed = lfsr(seed);
    wr(`OFS_RAM_RETAIN, seed);
    wr(`OFS_WAKE_EN, 32'h2);
    wr(`OFS_SLEEP_CTRL, 32'h5);
    settle();
    check({aon, core, flash, r18, r125}, 5'h10);
    check({ram_pwr, ram_keep, keep_reg}, {4'h0, seed[3:0], |seed[3:0]});
    wake_by_pin();
    check({xtal, r18, r125, flash}, 4'h7);
    rd_check(`OFS_RST_CAUSE, 32'h100);
    // Deep sleep 2: the timer stands still and cannot wake, even when enabled
    wr(`OFS_WAKE_EN, 32'h3);
    rd(`OFS_SLP_COUNT, rd_v);
    wr(`OFS_SLP_CMP, rd_v + 32'h3);
    wr(`OFS_SLEEP_CTRL, 32'h6);
    repeat (100) settle();
    check(core, 1'b0);
    wake_by_pin();
    // Deep sleep 1 woken by the timer alone, ticking from the 1 kHz source
    wr(`OFS_CLK_CTRL, 32'h2);
    wr(`OFS_WAKE_EN, 32'h1);
    rd(`OFS_SLP_COUNT, rd_v);
    wr(`OFS_SLP_CMP, rd_v + 32'h4);
    wr(`OFS_SLEEP_CTRL, 32'h5);
    settle();
    check(core, 1'b0);
    // The slow tick needs two more steps; the fast one would have woken by now
    repeat (24) settle();
    check(core, 1'b0);
    wait_run(400);
    // Emulated deep sleep: core stays on, debug units keep their state
    wr(`OFS_WAKE_EN, 32'h2);
    wr(`OFS_SLEEP_CTRL, 32'h7);
    settle();
    check({core, flash, periph_rst, cpu_rst, debug_rst}, 5'h1e);
    wake_by_pin();
    // Lockup is harmless while the watchdog is off
    @(posedge sys_clk);
    cpu_lockup <= 1'b1;
    repeat (3) settle();
    check(cpu_rst, 1'b0);
    @(posedge sys_clk);
    cpu_lockup <= 1'b0;
    wr(`OFS_CLK_CTRL, 32'h4);
    repeat (3) begin
      repeat (40) @(posedge sys_clk);
      wr(`OFS_WDOG_KICK, 32'h0);
    end
    check(cpu_rst, 1'b0);
    repeat (72) settle();
    check(cpu_rst, 1'b1);
    wait_run(60);
    rd_check(`OFS_RST_CAUSE, 32'h008);
    wr(`OFS_SW_RESET, 32'h1);
    repeat (2) settle();
    wait_run(60);
    rd_check(`OFS_RST_CAUSE, 32'h010);
    // Lockup with the watchdog armed resets at once
    wr(`OFS_CLK_CTRL, 32'h4);
    @(posedge sys_clk);
    cpu_lockup <= 1'b1;
    @(posedge sys_clk);
    cpu_lockup <= 1'b0;
    settle();
    check(cpu_rst, 1'b1);
    wait_run(60);
    rd_check(`OFS_RST_CAUSE, 32'h008);
    // Every external reset source, one at a time
    for (k = 0; k < 8; k++) begin
      if (k != 3 && k != 4) begin
        @(posedge sys_clk);
        src[k] <= 1'b1;
        repeat (2) settle();
        check({cpu_rst, periph_rst, debug_rst}, {2'b11, k < 2 || k == 7});
        src[k] <= 1'b0;
        repeat (2) settle();
        wait_run(60);
        rd_check(`OFS_RST_CAUSE, 32'h1 << k);
      end
    end
    finish_test();
  end
endmodule
